// File: inc/mie_consts.vh
// Purpose: Constants of the instruction execution core: offsets, fields, resets, opcodes, timing.
// Assumes: Included by every design file of the core by bare name.
// Notes:   Definitions only.
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH

// Timing: one machine cycle is four system clocks
`define MIE_MC_CLKS        4
`define MIE_PHASE_LAST     2'd3

// Register port offsets
`define MIE_REG_CTRL       3'h0
`define MIE_REG_STATUS     3'h1
`define MIE_REG_ACC        3'h2
`define MIE_REG_WDT        3'h3
`define MIE_REG_STK_TOP    3'h4
`define MIE_REG_STK_LEVEL  3'h5

// Control register fields and reset value
`define MIE_CTRL_WDT_EN    0
`define MIE_CTRL_TWO_CLR   1
`define MIE_CTRL_RESET     2'h1

// Status register fields
`define MIE_ST_C           0
`define MIE_ST_AC          1
`define MIE_ST_Z           2
`define MIE_ST_OV          3
`define MIE_ST_PDF         4
`define MIE_ST_TO          5

// Data memory address of the program counter low byte
`define MIE_PCL_ADDR       8'h06

// Watchdog terminal count
`define MIE_WDT_MAX        8'hff

// Reset values
`define MIE_ACC_RESET      8'h00
`define MIE_PC_RESET       15'h0000

// Opcodes
`define MIE_OP_NOP         5'h00
`define MIE_OP_ADD_M       5'h01
`define MIE_OP_ADDM        5'h02
`define MIE_OP_ADD_I       5'h03
`define MIE_OP_ADC_M       5'h04
`define MIE_OP_ADCM        5'h05
`define MIE_OP_AND_M       5'h06
`define MIE_OP_ANDM        5'h07
`define MIE_OP_AND_I       5'h08
`define MIE_OP_MOV_MA      5'h09
`define MIE_OP_CLR_BIT     5'h0a
`define MIE_OP_SET_BIT     5'h0b
`define MIE_OP_SZ_BIT      5'h0c
`define MIE_OP_SNZ_BIT     5'h0d
`define MIE_OP_SZ_M        5'h0e
`define MIE_OP_JMP         5'h0f
`define MIE_OP_CALL        5'h10
`define MIE_OP_WATCHDOG_CLEAR_INSTR     5'h11
`define MIE_OP_WATCHDOG_PRECLEAR_A    5'h12
`define MIE_OP_WATCHDOG_PRECLEAR_B    5'h13

`endif

// File: hw/mie_wdt.v
// Purpose: Watchdog counter with full clear and paired pre-clear handling.
// Assumes: Clear inputs are one-cycle pulses issued when an instruction is taken.
// Notes:   In two-clear mode both pre-clear instructions must be executed, in either order, to clear.
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_wdt (
	input  wire       clk_in,
	input  wire       reset_in,
	input  wire       tick_in,
	input  wire       enable_in,
	input  wire       two_clear_in,
	input  wire       clr_full_in,
	input  wire       clr_a_in,
	input  wire       clr_b_in,
	output reg  [7:0] count_out,
	output wire       overflow_out,
	output wire       pre_cleared_out
);

	reg pend_a;
	reg pend_b;
	wire clears;

	// A pre-clear counts only when the partner instruction is pending, or always in one-clear mode
	assign pre_cleared_out = two_clear_in ? ((clr_a_in & pend_b) | (clr_b_in & pend_a))
	                                      : (clr_a_in | clr_b_in);
	assign clears = clr_full_in | pre_cleared_out;
	assign overflow_out = enable_in & tick_in & (count_out == `MIE_WDT_MAX) & ~clears;

	// Counter advances once per machine cycle, clears take priority
	always @(posedge clk_in) begin
		if (reset_in) begin
			count_out <= 8'h00;
		end else if (clears) begin
			count_out <= 8'h00;
		end else if (enable_in && tick_in) begin
			count_out <= count_out + 8'h01;
		end
	end

	// Pending pre-clear halves
	always @(posedge clk_in) begin
		if (reset_in) begin
			pend_a <= 1'b0;
			pend_b <= 1'b0;
		end else if (clears || !two_clear_in) begin
			pend_a <= 1'b0;
			pend_b <= 1'b0;
		end else begin
			if (clr_a_in) begin
				pend_a <= 1'b1;
			end
			if (clr_b_in) begin
				pend_b <= 1'b1;
			end
		end
	end

endmodule

// File: hw/mie_core.v
// Purpose: Execution core for a subset of an 8-bit RISC-like instruction set.
// Assumes: mem_rdata_in holds the byte at instr_addr_in in the cycle an instruction is offered.
// Notes:   Instructions are taken on a machine-cycle boundary while ready_out is high.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_core (
	input  wire        core_clk_in,
	input  wire        reset_in,
	input  wire        instr_valid_in,
	input  wire [4:0]  instr_op_in,
	input  wire [7:0]  instr_addr_in,
	input  wire [7:0]  instr_imm_in,
	input  wire [2:0]  instr_bit_in,
	input  wire [14:0] instr_target_in,
	input  wire [7:0]  mem_rdata_in,
	input  wire        powerdown_set_in,
	input  wire [2:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_we_in,
	input  wire        reg_re_in,
	output reg         ready_out,
	output reg         taken_out,
	output reg  [7:0]  mem_addr_out,
	output reg  [7:0]  mem_wdata_out,
	output reg         mem_we_out,
	output reg  [7:0]  acc_out,
	output reg  [14:0] pc_out,
	output reg         timeout_flag_out,
	output reg         powerdown_flag_out,
	output reg  [7:0]  reg_rdata_out
);

	reg  [1:0]  phase;
	reg  [1:0]  mc_left;
	reg  [1:0]  ctrl;
	reg         carry_flag;
	reg         aux_carry_flag;
	reg         zero_flag;
	reg         overflow_flag;
	reg  [14:0] stack_mem [0:7];
	reg  [2:0]  stack_ptr;
	reg  [3:0]  stack_level;
	reg  [7:0]  next_acc;
	reg         next_c;
	reg         next_ac;
	reg         next_z;
	reg         next_ov;
	reg         mem_wr;
	reg  [7:0]  mem_wd;
	reg         skip;
	reg         jump;
	reg         call;
	reg  [1:0]  base_mc;
	reg  [7:0]  opb;
	reg         cin;
	wire        mc_tick;
	wire        take;
	wire        pcl_write;
	wire [1:0]  total_mc;
	wire [4:0]  sum_lo;
	wire [8:0]  sum_full;
	wire [7:0]  bit_mask;
	wire [14:0] pc_inc;
	wire [7:0]  wdt_count;
	wire        wdt_ovf;
	wire        wdt_pre_ok;
	wire        op_wdt_full;
	wire        op_wdt_a;
	wire        op_wdt_b;

	// Machine-cycle enable: one pulse every four system clocks
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			phase <= 2'd0;
		end else begin
			phase <= phase + 2'd1;
		end
	end
	assign mc_tick = (phase == `MIE_PHASE_LAST);
	assign take = mc_tick & instr_valid_in & (mc_left == 2'd0);

	// Adder shared by the add instructions, carry in only for the carry forms
	always @* begin
		opb = ((instr_op_in == `MIE_OP_ADD_I) || (instr_op_in == `MIE_OP_AND_I)) ?
		      instr_imm_in : mem_rdata_in;
		cin = ((instr_op_in == `MIE_OP_ADC_M) || (instr_op_in == `MIE_OP_ADCM)) ?
		      carry_flag : 1'b0;
	end
	assign sum_lo = {1'b0, acc_out[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	assign sum_full = {1'b0, acc_out} + {1'b0, opb} + {8'h00, cin};
	assign bit_mask = 8'h01 << instr_bit_in;
	assign pc_inc = pc_out + 15'h0001;

	// Instruction decode and result selection
	always @* begin
		next_acc = acc_out;
		next_c = carry_flag;
		next_ac = aux_carry_flag;
		next_z = zero_flag;
		next_ov = overflow_flag;
		mem_wr = 1'b0;
		mem_wd = mem_rdata_in;
		skip = 1'b0;
		jump = 1'b0;
		call = 1'b0;
		base_mc = 2'd1;
		case (instr_op_in)
			`MIE_OP_ADD_M, `MIE_OP_ADD_I, `MIE_OP_ADC_M, `MIE_OP_ADDM, `MIE_OP_ADCM: begin
				next_c = sum_full[8];
				next_ac = sum_lo[4];
				next_z = (sum_full[7:0] == 8'h00);
				next_ov = (acc_out[7] == opb[7]) && (sum_full[7] != acc_out[7]);
				if ((instr_op_in == `MIE_OP_ADDM) || (instr_op_in == `MIE_OP_ADCM)) begin
					mem_wr = 1'b1;
					mem_wd = sum_full[7:0];
				end else begin
					next_acc = sum_full[7:0];
				end
			end
			`MIE_OP_AND_M, `MIE_OP_AND_I, `MIE_OP_ANDM: begin
				next_z = ((acc_out & opb) == 8'h00);
				if (instr_op_in == `MIE_OP_ANDM) begin
					mem_wr = 1'b1;
					mem_wd = acc_out & opb;
				end else begin
					next_acc = acc_out & opb;
				end
			end
			`MIE_OP_MOV_MA: begin
				mem_wr = 1'b1;
				mem_wd = acc_out;
			end
			`MIE_OP_CLR_BIT: begin
				mem_wr = 1'b1;
				mem_wd = mem_rdata_in & ~bit_mask;
			end
			`MIE_OP_SET_BIT: begin
				mem_wr = 1'b1;
				mem_wd = mem_rdata_in | bit_mask;
			end
			`MIE_OP_SZ_BIT: begin
				skip = ((mem_rdata_in & bit_mask) == 8'h00);
			end
			`MIE_OP_SNZ_BIT: begin
				skip = ((mem_rdata_in & bit_mask) != 8'h00);
			end
			`MIE_OP_SZ_M: begin
				skip = (mem_rdata_in == 8'h00);
			end
			`MIE_OP_JMP: begin
				jump = 1'b1;
				base_mc = 2'd2;
			end
			`MIE_OP_CALL: begin
				call = 1'b1;
				base_mc = 2'd2;
			end
			default: begin
				next_acc = acc_out;
			end
		endcase
	end

	// Extra machine cycle for a low-byte program counter load or a taken skip
	assign pcl_write = mem_wr & (instr_addr_in == `MIE_PCL_ADDR);
	assign total_mc = base_mc + {1'b0, pcl_write | skip};

	// Busy count in machine cycles; ready again after the last one
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			mc_left <= 2'd0;
			ready_out <= 1'b0;
		end else begin
			if (take) begin
				mc_left <= total_mc - 2'd1;
			end else if (mc_tick && (mc_left != 2'd0)) begin
				mc_left <= mc_left - 2'd1;
			end
			ready_out <= (mc_left == 2'd0) && !take;
		end
	end

	// Architectural state: accumulator, flags, program counter, memory write
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			acc_out <= `MIE_ACC_RESET;
			pc_out <= `MIE_PC_RESET;
			carry_flag <= 1'b0;
			aux_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			overflow_flag <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= 8'h00;
			mem_wdata_out <= 8'h00;
			taken_out <= 1'b0;
		end else begin
			mem_we_out <= take & mem_wr;
			taken_out <= take;
			if (take) begin
				acc_out <= next_acc;
				carry_flag <= next_c;
				aux_carry_flag <= next_ac;
				zero_flag <= next_z;
				overflow_flag <= next_ov;
				mem_addr_out <= instr_addr_in;
				mem_wdata_out <= mem_wd;
				if (jump || call) begin
					pc_out <= instr_target_in;
				end else if (pcl_write) begin
					pc_out <= {pc_out[14:8], mem_wd};
				end else if (skip) begin
					pc_out <= pc_out + 15'h0002;
				end else begin
					pc_out <= pc_inc;
				end
			end
		end
	end

	// Hardware stack: the return address goes in on the same edge as the jump takes effect
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			stack_ptr <= 3'd0;
			stack_level <= 4'd0;
		end else if (take && call) begin
			stack_mem[stack_ptr] <= pc_inc;
			stack_ptr <= stack_ptr + 3'd1;
			if (stack_level != 4'd8) begin
				stack_level <= stack_level + 4'd1;
			end
		end
	end

	// Watchdog clear requests from the instruction stream
	assign op_wdt_full = take & (instr_op_in == `MIE_OP_WATCHDOG_CLEAR_INSTR);
	assign op_wdt_a = take & (instr_op_in == `MIE_OP_WATCHDOG_PRECLEAR_A);
	assign op_wdt_b = take & (instr_op_in == `MIE_OP_WATCHDOG_PRECLEAR_B);

	mie_wdt u_wdt (
		.clk_in          (core_clk_in),
		.reset_in        (reset_in),
		.tick_in         (mc_tick),
		.enable_in       (ctrl[`MIE_CTRL_WDT_EN]),
		.two_clear_in    (ctrl[`MIE_CTRL_TWO_CLR]),
		.clr_full_in     (op_wdt_full),
		.clr_a_in        (op_wdt_a),
		.clr_b_in        (op_wdt_b),
		.count_out       (wdt_count),
		.overflow_out    (wdt_ovf),
		.pre_cleared_out (wdt_pre_ok)
	);

	// Time-out and power-down flags; a power-down set wins over a clear, a clear masks a same-cycle watchdog overflow
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			timeout_flag_out <= 1'b0;
			powerdown_flag_out <= 1'b0;
		end else begin
			if (wdt_ovf) begin
				timeout_flag_out <= 1'b1;
			end else if (op_wdt_full || wdt_pre_ok) begin
				timeout_flag_out <= 1'b0;
			end
			if (powerdown_set_in) begin
				powerdown_flag_out <= 1'b1;
			end else if (op_wdt_full || wdt_pre_ok) begin
				powerdown_flag_out <= 1'b0;
			end
		end
	end

	// Register port: control write, readback one cycle after the read strobe
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			ctrl <= `MIE_CTRL_RESET;
			reg_rdata_out <= 8'h00;
		end else begin
			if (reg_we_in && (reg_addr_in == `MIE_REG_CTRL)) begin
				ctrl <= reg_wdata_in[1:0];
			end
			if (!reg_re_in) begin
				reg_rdata_out <= 8'h00;
			end else if (reg_addr_in == `MIE_REG_CTRL) begin
				reg_rdata_out <= {6'h00, ctrl};
			end else if (reg_addr_in == `MIE_REG_STATUS) begin
				reg_rdata_out <= {2'b00, timeout_flag_out, powerdown_flag_out,
				                  overflow_flag, zero_flag, aux_carry_flag, carry_flag};
			end else if (reg_addr_in == `MIE_REG_ACC) begin
				reg_rdata_out <= acc_out;
			end else if (reg_addr_in == `MIE_REG_WDT) begin
				reg_rdata_out <= wdt_count;
			end else if (reg_addr_in == `MIE_REG_STK_TOP) begin
				reg_rdata_out <= stack_mem[stack_ptr - 3'd1][7:0];
			end else if (reg_addr_in == `MIE_REG_STK_LEVEL) begin
				reg_rdata_out <= {4'h0, stack_level};
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

endmodule

// File: verif/mie_core_sva.sv
// Purpose: Port checks on instruction timing and flags of the core.
// Assumes: Bound to mie_core, one clock.
// Notes:   Stalls counted in system clocks.
`timescale 1ns/1ps
module mie_core_sva (
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic        taken_out,
	input wire logic        ready_out,
	input wire logic        mem_we_out,
	input wire logic [7:0]  mem_addr_out,
	input wire logic [7:0]  mem_wdata_out,
	input wire logic [14:0] pc_out,
	input wire logic        reg_re_in,
	input wire logic [2:0]  reg_addr_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        powerdown_set_in,
	input wire logic        powerdown_flag_out,
	input wire logic        timeout_flag_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Quiet spans after a take: one and two machine cycles
	sequence quiet3; (!taken_out) [*3]; endsequence
	sequence quiet7; (!taken_out) [*7]; endsequence
	// Instruction timing
	take_spacing_a: assert property (taken_out |=> quiet3)
		else $error("take too soon");
	busy_after_take_a: assert property (taken_out |-> !ready_out)
		else $error("ready during take");
	pcl_stall_a: assert property (mem_we_out && mem_addr_out == 8'h06 |->
		pc_out[7:0] == mem_wdata_out ##1 quiet7) else $error("low pc write");
	skip_stall_a: assert property (taken_out && pc_out == $past(pc_out) + 15'h2 |=> quiet7)
		else $error("skip too short");
	write_on_take_a: assert property (mem_we_out |-> taken_out)
		else $error("stray write");
	// Flags
	pdown_set_a: assert property (powerdown_set_in |=> powerdown_flag_out)
		else $error("powerdown not set");
	flag_fall_a: assert property ($fell(timeout_flag_out) || $fell(powerdown_flag_out)
		|-> taken_out) else $error("flag fell alone");
	// Register port
	read_idle_a: assert property (!reg_re_in |=> reg_rdata_out == 8'h00)
		else $error("read data not idle");
	status_read_a: assert property (reg_re_in && reg_addr_in == 3'h1 |=>
		reg_rdata_out[5:4] == {$past(timeout_flag_out), $past(powerdown_flag_out)})
		else $error("status mismatch");
endmodule

// File: verif/mie_core_tb_top.sv
// Purpose: Self-checking bench for the execution core.
// Assumes: Operand byte is driven with each offer.
// Notes:   Random operands, seed 96.
`timescale 1ns/1ps
`include "mie_consts.vh"
module mie_core_tb_top;
	reg         clk = 1'b0, rst = 1'b1, vld = 1'b0, pds = 1'b0, rwe = 1'b0, rre = 1'b0;
	reg  [4:0]  op = 5'h0, o5;
	reg  [2:0]  bt = 3'h0, ra = 3'h0;
	reg  [14:0] tgt = 15'h0, p0, px, pd;
	reg  [7:0]  ad = 8'h0, imm = 8'h0, rd = 8'h0, rwd = 8'h0, x8, r8, wd, m_acc, e8;
	reg         m_c, m_h, m_z, m_v, s, cwe;
	wire        tk, mwe, tmo, pwd;
	wire [7:0]  mwd, acc, rdo;
	wire [14:0] pc;
	integer     cyc = 0, last = 0, gap, n, i, k, fails = 0, cmp_count = 0, seed = 96;
	mie_core uut (.core_clk_in(clk), .reset_in(rst), .instr_valid_in(vld), .instr_op_in(op),
		.instr_addr_in(ad), .instr_imm_in(imm), .instr_bit_in(bt), .instr_target_in(tgt),
		.mem_rdata_in(rd), .powerdown_set_in(pds), .reg_addr_in(ra), .reg_wdata_in(rwd),
		.reg_we_in(rwe), .reg_re_in(rre), .ready_out(), .taken_out(tk), .mem_addr_out(),
		.mem_wdata_out(mwd), .mem_we_out(mwe), .acc_out(acc), .pc_out(pc),
		.timeout_flag_out(tmo), .powerdown_flag_out(pwd), .reg_rdata_out(rdo));
	// Clock and cycle count
	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	task end_sim;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [23:0] got, input [23:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Returns {ov, z, half carry, carry, sum}
	function [11:0] f_add(input [7:0] a, input [7:0] b, input ci);
		reg [8:0] t;
		begin
			t = a + b + ci;
			f_add = {a[7] == b[7] && t[7] != a[7], t[7:0] == 8'h0,
				a[3:0] + b[3:0] + ci > 5'hf, t[8], t[7:0]};
		end
	endfunction
	// Register port strobes
	task rr(input [2:0] a);
		begin
			@(posedge clk);
			rre <= 1'b1;
			ra <= a;
			@(posedge clk);
			rre <= 1'b0;
			#1 r8 = rdo;
		end
	endtask
	task rw(input [2:0] a, input [7:0] d);
		begin
			@(posedge clk);
			rwe <= 1'b1;
			ra <= a;
			rwd <= d;
			@(posedge clk);
			rwe <= 1'b0;
		end
	endtask
	task pulse;
		begin
			@(posedge clk);
			pds <= 1'b1;
			@(posedge clk);
			pds <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Offer held until taken, bounded
	task ex(input [4:0] o, input [7:0] a, input [7:0] m, input [2:0] b, input [14:0] t);
		begin
			@(posedge clk);
			vld <= 1'b1;
			op <= o;
			ad <= a;
			rd <= m;
			imm <= m;
			bt <= b;
			tgt <= t;
			p0 = pc;
			n = 0;
			do begin
				@(posedge clk);
				#1 n = n + 1;
			end while (tk !== 1'b1 && n < 40);
			gap = cyc - last;
			last = cyc;
			if (mwe === 1'b1) begin
				cwe = 1'b1;
				wd = mwd;
			end
			if (n >= 40) begin
				fails = fails + 1;
				end_sim;
			end else begin
				@(posedge clk);
				vld <= 1'b0;
			end
		end
	endtask
	task run(input [4:0] o, input [7:0] a, input [7:0] m, input [2:0] b, input [14:0] t,
		input integer mc);
		begin
			cwe = 1'b0;
			ex(o, a, m, b, t);
			px = pc;
			pd = px - p0;
			ex(`MIE_OP_NOP, 8'h0, 8'h0, 3'h0, 15'h0);
			chk(gap, 4 * mc);
		end
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rr(3'h0);
		chk(r8, 8'h01);
		rr(3'h6);
		chk(r8, 8'h00);
		run(`MIE_OP_AND_I, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		{m_v, m_h, m_c, m_acc, m_z} = {3'h0, 8'h0, 1'b1};
		for (i = 0; i < 16; i = i + 1) begin
			k = i < 3 ? 0 : $random(seed) & 3;
			x8 = i == 0 ? 8'h7f : i == 1 ? 8'h01 : i == 2 ? 8'h80 : $random(seed);
			if (k == 3) begin
				m_acc = m_acc & x8;
				m_z = m_acc == 8'h0;
			end else begin
				{m_v, m_z, m_h, m_c, m_acc} = f_add(m_acc, x8, k == 2 && m_c);
			end
			run(k == 0 ? `MIE_OP_ADD_I : k == 1 ? `MIE_OP_ADD_M : k == 2 ? `MIE_OP_ADC_M :
				`MIE_OP_AND_M, 8'h20, x8, 3'h0, 15'h0, 1);
			chk(acc, m_acc);
			rr(3'h1);
			chk(r8[3:0], {m_v, m_z, m_h, m_c});
		end
		// Memory-result forms: sum or product lands in memory, accumulator kept
		for (i = 0; i < 6; i = i + 1) begin
			k = i % 3;
			x8 = $random(seed);
			if (k == 2) begin
				e8 = m_acc & x8;
				m_z = e8 == 8'h0;
			end else begin
				{m_v, m_z, m_h, m_c, e8} = f_add(m_acc, x8, k == 1 && m_c);
			end
			o5 = k == 0 ? `MIE_OP_ADDM : k == 1 ? `MIE_OP_ADCM : `MIE_OP_ANDM;
			run(o5, 8'h21, x8, 3'h0, 15'h0, 1);
			chk({cwe, wd, acc}, {1'b1, e8, m_acc});
			rr(3'h1);
			chk(r8[3:0], {m_v, m_z, m_h, m_c});
		end
		$display("arith done");
		for (i = 0; i < 16; i = i + 1) begin
			x8 = $random(seed);
			s = x8[i % 8] ^ (i < 8);
			run(i < 8 ? `MIE_OP_SZ_BIT : `MIE_OP_SNZ_BIT, 8'h30, x8, i[2:0], 15'h0, 1 + s);
			chk(pd, 1 + s);
		end
		run(`MIE_OP_SZ_M, 8'h30, 8'h00, 3'h0, 15'h0, 2);
		// Bit set and clear over every index
		for (i = 0; i < 8; i = i + 1) begin
			x8 = $random(seed);
			run(`MIE_OP_SET_BIT, 8'h31, x8, i[2:0], 15'h0, 1);
			chk({cwe, wd}, {1'b1, x8 | (8'h01 << i)});
			run(`MIE_OP_CLR_BIT, 8'h31, x8, i[2:0], 15'h0, 1);
			chk({cwe, wd}, {1'b1, x8 & ~(8'h01 << i)});
		end
		run(`MIE_OP_MOV_MA, `MIE_PCL_ADDR, 8'h0, 3'h0, 15'h0, 2);
		chk({cwe, wd, px[7:0]}, {1'b1, m_acc, m_acc});
		run(`MIE_OP_MOV_MA, 8'h40, 8'h0, 3'h0, 15'h0, 1);
		run(`MIE_OP_JMP, 8'h0, 8'h0, 3'h0, 15'h1234, 2);
		chk(px, 15'h1234);
		run(`MIE_OP_CALL, 8'h0, 8'h0, 3'h0, 15'h0500, 2);
		chk(px, 15'h0500);
		rr(3'h4);
		chk(r8, 8'h36);
		rr(3'h5);
		chk(r8, 8'h01);
		$display("branch done");
		// Let the watchdog run out, then clear it
		repeat (1100) @(posedge clk);
		pulse;
		chk({tmo, pwd}, 2'h3);
		rw(3'h0, 8'h03);
		run(`MIE_OP_WATCHDOG_PRECLEAR_A, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		chk({tmo, pwd}, 2'h3);
		run(`MIE_OP_WATCHDOG_PRECLEAR_A, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		chk({tmo, pwd}, 2'h3);
		run(`MIE_OP_WATCHDOG_PRECLEAR_B, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		chk({tmo, pwd}, 2'h0);
		// Run out again so the full clear has both flags to drop
		repeat (1100) @(posedge clk);
		pulse;
		chk({tmo, pwd}, 2'h3);
		ex(`MIE_OP_WATCHDOG_CLEAR_INSTR, 8'h0, 8'h0, 3'h0, 15'h0);
		rr(3'h3);
		chk({tmo, pwd, r8}, 10'h000);
		rw(3'h0, 8'h01);
		pulse;
		run(`MIE_OP_WATCHDOG_PRECLEAR_B, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		chk(pwd, 1'b0);
		// Disabled watchdog holds at zero after a full clear
		rw(3'h0, 8'h00);
		run(`MIE_OP_WATCHDOG_CLEAR_INSTR, 8'h0, 8'h0, 3'h0, 15'h0, 1);
		repeat (40) @(posedge clk);
		rr(3'h3);
		chk(r8, 8'h00);
		$display("watchdog done");
		end_sim;
	end
endmodule
bind mie_core mie_core_sva chk_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
	.taken_out(taken_out), .ready_out(ready_out), .mem_we_out(mem_we_out),
	.mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .pc_out(pc_out),
	.reg_re_in(reg_re_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
	.powerdown_set_in(powerdown_set_in), .powerdown_flag_out(powerdown_flag_out),
	.timeout_flag_out(timeout_flag_out));
